// *** tb/test_travel_limit_supervisor.sv ***
`timescale 1ns/1ps
module test_travel_limit_supervisor;
  import tls_pkg::*;
  typedef struct packed {
    tls_cmd_kind_t           kind;
    logic signed [POS_W-1:0] target;
    logic                    clamp;
  } tls_exp_t;
  localparam logic signed [POS_W-1:0] FL = FWD_LIM_RST;
  localparam logic signed [POS_W-1:0] RL = REV_LIM_RST;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                    clk_sys = 1'b0;
  logic                    arst_n  = 1'b0;
  logic                    restart = 1'b0;
  logic [3:0]              otw_set = 4'h0;
  tls_slim_cfg_t           slim    = '{4'h3, 4'h0};
  logic signed [POS_W-1:0] fwd_lim = FL;
  logic signed [POS_W-1:0] rev_lim = RL;
  logic signed [POS_W-1:0] fb_pos  = '0;
  logic signed [POS_W-1:0] t;
  logic                    fwd_blk = 1'b0;
  logic                    rev_blk = 1'b0;
  logic                    servo   = 1'b0;
  logic                    org     = 1'b0;
  logic                    mdone   = 1'b0;
  logic                    clr     = 1'b0;
  logic                    ce      = 1'b1;
  tls_cmd_t                req     = '0;
  tls_cmd_t                host_cmd;
  logic                    warn, stop_f, stop_r, armed, ex_v, clamped, ready;
  tls_cmd_kind_t           ex_k;
  logic signed [POS_W-1:0] ex_t;
  tls_exp_t                exp_q[$];
  tls_exp_t                e;
  int                      errors  = 0;
  int                      n_tests = 0;
  int                      cyc     = 0;

  // Control cycle clock, 40 ns
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  tls_host_model host_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .servo_power_on_cmd(servo), .req(req), .host_cmd(host_cmd),
    .ready(ready));

  tls_supervisor dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(ce), .restart(restart), .overtravel_warning_setting(otw_set),
    .soft_limit_function_setting(slim), .forward_soft_limit_value(fwd_lim),
    .reverse_soft_limit_value(rev_lim), .forward_travel_block_input(fwd_blk),
    .reverse_travel_block_input(rev_blk), .feedback_position(fb_pos),
    .servo_power_on_cmd(servo), .host_cmd(host_cmd),
    .origin_return_done(org), .motion_done(mdone), .clear_alarm_cmd(clr),
    .overtravel_warning_code(warn), .ot_stop_fwd(stop_f),
    .ot_stop_rev(stop_r), .soft_limit_armed(armed), .exec_valid(ex_v),
    .exec_kind(ex_k), .exec_target(ex_t), .target_clamped(clamped));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Lands between edges so registered outputs have settled
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input tls_cmd_kind_t k, input logic signed [31:0] tg,
                      input logic rv, input logic signed [31:0] et,
                      input logic ec);
    @(posedge clk_sys);
    exp_q.push_back('{k, et, ec});
    req <= '{1'b1, k, tg, rv};
    tick(1);
    req.valid <= 1'b0;
    look(3);
  endtask : send

  task automatic pulse_clr();
    tick(1);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
  endtask : pulse_clr

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Scoreboard: each executed command against the oldest note
  always @(negedge clk_sys) begin
    if (ex_v === 1'b1 && exp_q.size() == 0) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, ex_k, TLS_CMD_NONE);
    end else if (ex_v === 1'b1) begin
      e = exp_q.pop_front();
      chk(ex_k, e.kind);
      chk(ex_t, e.target);
      chk(clamped, e.clamp);
    end else begin
      chk(ex_k, TLS_CMD_NONE);
    end
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h6aa392a7));
    look(12);
    chk({warn, stop_f, armed, ex_v}, 4'h0);
    tick(1);
    arst_n <= 1'b1;
    servo  <= 1'b1;
    while (ready !== 1'b1) tick(1);
    // Setting ignored until restart
    otw_set <= OTW_DIGIT_ON;
    fwd_blk <= 1'b1;
    look(3);
    chk(warn, 1'b0);
    chk(stop_f, 1'b1);
    tick(1);
    fwd_blk <= 1'b0;
    restart <= 1'b1;
    tick(1);
    restart <= 1'b0;
    tick(2);
    fwd_blk <= 1'b1;
    look(3);
    chk(warn, 1'b1);
    chk({stop_f, stop_r}, 2'b10);
    send(TLS_CMD_OTHER, 32'sd5, 1'b0, 32'sd5, 1'b0);
    pulse_clr();
    look(3);
    chk(warn, 1'b0);
    tick(1);
    fwd_blk <= 1'b0;
    tick(2);
    fwd_blk <= 1'b1;
    look(3);
    chk(warn, 1'b1);
    tick(1);
    fwd_blk <= 1'b0;
    pulse_clr();
    // Servo off, then on during overtravel: no warning
    servo <= 1'b0;
    tick(1);
    rev_blk <= 1'b1;
    look(3);
    chk({warn, stop_r}, 2'b01);
    tick(1);
    servo <= 1'b1;
    look(3);
    chk(warn, 1'b0);
    tick(1);
    rev_blk <= 1'b0;
    while (ready !== 1'b1) tick(1);
    // Forward move: reverse input is not relevant
    send(TLS_CMD_POSITIONING, 32'sd1000, 1'b0, 32'sd1000, 1'b0);
    tick(1);
    rev_blk <= 1'b1;
    look(3);
    chk(warn, 1'b0);
    tick(1);
    rev_blk <= 1'b0;
    mdone   <= 1'b1;
    tick(1);
    mdone   <= 1'b0;
    tick(1);
    rev_blk <= 1'b1;
    look(3);
    chk(warn, 1'b1);
    tick(1);
    rev_blk <= 1'b0;
    pulse_clr();
    // Soft limits unarmed, then armed
    slim   <= '{SLIM_EN_BOTH, SLIM_CHK_ON};
    fb_pos <= FL + 1;
    look(3);
    chk(stop_f, 1'b0);
    send(TLS_CMD_POSITIONING, FL + 5, 1'b0, FL + 5, 1'b0);
    send(TLS_CMD_SET_POS, 32'sd0, 1'b1, 32'sd0, 1'b0);
    chk({armed, stop_f}, 2'b11);
    chk(warn, 1'b1);
    pulse_clr();
    // Each enable digit against both limits
    for (int d = 0; d < 5; d++) begin
      tick(1);
      slim.enable_digit <= 4'(d);
      fb_pos            <= FL + 1;
      look(2);
      chk(stop_f, d < 2);
      tick(1);
      fb_pos <= RL - 1;
      look(2);
      chk(stop_r, d == 0 || d == 2);
    end
    tick(1);
    slim   <= '{SLIM_EN_BOTH, SLIM_CHK_ON};
    fb_pos <= FL;
    look(2);
    chk({stop_f, stop_r}, 2'b00);
    send(TLS_CMD_POSITIONING, FL + 7, 1'b0, FL, 1'b1);
    send(TLS_CMD_INTERP, RL - 7, 1'b0, RL, 1'b1);
    for (int i = 0; i < 4; i++) begin
      t = $signed($urandom_range(2000000, 0)) - 32'sd1000000;
      send(TLS_CMD_INTERP, t, 1'b0, t, 1'b0);
    end
    tick(1);
    slim.enable_digit <= SLIM_EN_FWD;
    send(TLS_CMD_INTERP, RL - 7, 1'b0, RL - 7, 1'b0);
    tick(1);
    slim <= '{SLIM_EN_BOTH, SLIM_CHK_OFF};
    send(TLS_CMD_POSITIONING, FL + 7, 1'b0, FL + 7, 1'b0);
    // New limits apply at once, saturated; then forward lowered to 1000
    tick(1);
    slim    <= '{SLIM_EN_BOTH, SLIM_CHK_ON};
    fwd_lim <= 32'sh7fffffff;
    look(2);
    send(TLS_CMD_POSITIONING, 32'sh7ffffff0, 1'b0, LIM_MAX, 1'b1);
    tick(1);
    fwd_lim <= 32'sd1000;
    send(TLS_CMD_POSITIONING, 32'sd2000, 1'b0, 32'sd1000, 1'b1);
    // Disarm, then arm by origin return
    send(TLS_CMD_SET_POS, 32'sd0, 1'b0, 32'sd0, 1'b0);
    chk(armed, 1'b0);
    tick(1);
    org <= 1'b1;
    tick(1);
    org <= 1'b0;
    look(2);
    chk(armed, 1'b1);
    // Clock enable low freezes the stop flops
    tick(1);
    ce     <= 1'b0;
    fb_pos <= 32'sd0;
    look(3);
    chk(stop_f, 1'b1);
    tick(1);
    ce <= 1'b1;
    look(2);
    chk(stop_f, 1'b0);
    look(5);
    chk(exp_q.size(), 0);
    give_verdict();
  end
endmodule : test_travel_limit_supervisor

// *** tb/tls_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Host controller model
// ****************************************************************
module tls_host_model
  import tls_pkg::*;
#(
  parameter int SETTLE = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              servo_power_on_cmd,
  input  wire tls_pkg::tls_cmd_t req,
  output tls_pkg::tls_cmd_t      host_cmd,
  output logic                   ready
);
  logic [7:0] wait_d;
  logic [7:0] wait_q;

  // settle after power
  // Motion held back until servo power has been on long enough
  always_comb begin
    wait_d = wait_q;
    if (!servo_power_on_cmd) begin
      wait_d = 8'h00;
    end else if (wait_q < 8'(SETTLE)) begin
      wait_d = wait_q + 8'h01;
    end
  end

  // commands issued regardless of warning
  // Warning is the host's concern; clears come from the bench
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_q   <= 8'h00;
      host_cmd <= '0;
    end else begin
      wait_q   <= wait_d;
      host_cmd <= '{req.valid && ready, req.kind, req.target, req.ref_valid};
    end
  end

  assign ready = (wait_q >= 8'(SETTLE));
endmodule : tls_host_model

// *** verilog/tls_limit_cmp.sv ***
`timescale 1ns/1ps
module tls_limit_cmp #(
  parameter int W = 32
) (
  input  wire logic signed [W-1:0] pos,
  input  wire logic signed [W-1:0] fwd_lim,
  input  wire logic signed [W-1:0] rev_lim,
  input  wire logic [1:0]          dir_en,
  input  wire logic                armed,
  output logic [1:0]               over
);

  // ****************************************************************
  // Per-direction compare
  // ****************************************************************

  // Index 0 is forward, index 1 reverse
  for (genvar i = 0; i < 2; i++) begin : g_dir
    logic beyond;
    assign beyond = (i == 0) ? (pos > fwd_lim) : (pos < rev_lim);
    assign over[i] = armed & dir_en[i] & beyond;
  end

endmodule : tls_limit_cmp

// *** verilog/tls_pkg.sv ***
package tls_pkg;

  // ****************************************************************
  // Widths and setting encodings
  // ****************************************************************

  // Signed position and limit width in command units
  localparam int POS_W = 32;

  // Overtravel warning setting, top digit
  localparam logic [3:0] OTW_DIGIT_RST = 4'h0;
  localparam logic [3:0] OTW_DIGIT_ON  = 4'h1;

  // Soft limit setting, lowest digit: direction enables
  localparam logic [3:0] SLIM_EN_BOTH = 4'h0;
  localparam logic [3:0] SLIM_EN_FWD  = 4'h1;
  localparam logic [3:0] SLIM_EN_REV  = 4'h2;
  localparam logic [3:0] SLIM_EN_NONE = 4'h3;

  // Soft limit setting, target check digit
  localparam logic [3:0] SLIM_CHK_OFF = 4'h0;
  localparam logic [3:0] SLIM_CHK_ON  = 4'h1;

  // ****************************************************************
  // Limit values
  // ****************************************************************

  // Defaults 819191808 and -819191808, range +-1073741823
  localparam logic signed [POS_W-1:0] FWD_LIM_RST = 32'sh30d3e000;
  localparam logic signed [POS_W-1:0] REV_LIM_RST = 32'shcf2c2000;
  localparam logic signed [POS_W-1:0] LIM_MAX     = 32'sh3fffffff;
  localparam logic signed [POS_W-1:0] LIM_MIN     = 32'shc0000001;

  // Direction index into two-bit limit vectors
  localparam int DIR_FWD = 0;
  localparam int DIR_REV = 1;

  // ****************************************************************
  // Types
  // ****************************************************************

  typedef enum logic [2:0] {
    TLS_CMD_NONE,
    TLS_CMD_POSITIONING,
    TLS_CMD_INTERP,
    TLS_CMD_ORIGIN,
    TLS_CMD_SET_POS,
    TLS_CMD_OTHER
  } tls_cmd_kind_t;

  // One host command, valid for one cycle
  typedef struct packed {
    logic                    valid;
    tls_cmd_kind_t           kind;
    logic signed [POS_W-1:0] target;
    logic                    ref_valid;
  } tls_cmd_t;

  // Soft limit function digits
  typedef struct packed {
    logic [3:0] enable_digit;
    logic [3:0] check_digit;
  } tls_slim_cfg_t;

  // Motion direction of the command in progress
  typedef enum logic [1:0] {
    TLS_ST_IDLE,
    TLS_ST_FWD,
    TLS_ST_REV
  } tls_motion_t;

endpackage : tls_pkg

// *** verilog/tls_supervisor.sv ***
// How it works
// - Warning enable digit 1 detects, 0 does not; sampled once after reset and at restart.
// - Warning is status only; it never drives any stop.
// - Commands are accepted and executed even while a warning is pending.
// - An active travel block input requests overtravel stop processing.
// - Passing an enabled soft limit requests the same overtravel stop.
// - Soft limits arm after origin return or set-position with valid flag.
// - Enable digit: 0 both, 1 forward, 2 reverse, 3 none; immediate.
// - Check digit 1 checks commanded targets against limits; 0 does not.
// - Target beyond a limit is replaced by the limit, decelerating there.
// - Limits are signed, saturated to +-1073741823, applied immediately.
// - Warning raised only with servo on, in command direction or idle.
// - Only clear alarm clears; reappears only after overtravel recurs.
// - A soft limit becoming the overtravel cause also raises the warning.
`timescale 1ns/1ps
module tls_supervisor
  import tls_pkg::*;
#(
  parameter int W = tls_pkg::POS_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  restart,
  input  wire logic [3:0]            overtravel_warning_setting,
  input  wire tls_pkg::tls_slim_cfg_t soft_limit_function_setting,
  input  wire logic signed [W-1:0]   forward_soft_limit_value,
  input  wire logic signed [W-1:0]   reverse_soft_limit_value,
  input  wire logic                  forward_travel_block_input,
  input  wire logic                  reverse_travel_block_input,
  input  wire logic signed [W-1:0]   feedback_position,
  input  wire logic                  servo_power_on_cmd,
  input  wire tls_pkg::tls_cmd_t     host_cmd,
  input  wire logic                  origin_return_done,
  input  wire logic                  motion_done,
  input  wire logic                  clear_alarm_cmd,
  output logic                       overtravel_warning_code,
  output logic                       ot_stop_fwd,
  output logic                       ot_stop_rev,
  output logic                       soft_limit_armed,
  output logic                       exec_valid,
  output tls_pkg::tls_cmd_kind_t     exec_kind,
  output logic signed [W-1:0]        exec_target,
  output logic                       target_clamped
);

  import tls_pkg::*;

  // ****************************************************************
  // Settings
  // ****************************************************************

  logic                boot_q;
  logic                warn_en_q;
  logic                warn_en_d;
  tls_slim_cfg_t       slim_q;
  logic signed [W-1:0] fwd_lim_q;
  logic signed [W-1:0] fwd_lim_d;
  logic signed [W-1:0] rev_lim_q;
  logic signed [W-1:0] rev_lim_d;
  logic [1:0]          dir_en;
  logic                chk_on;

  // Warning enable latched once after reset and on restart only
  always_comb begin
    fwd_lim_d = forward_soft_limit_value;
    rev_lim_d = reverse_soft_limit_value;
    if (fwd_lim_d > LIM_MAX) begin
      fwd_lim_d = LIM_MAX;
    end else if (fwd_lim_d < LIM_MIN) begin
      fwd_lim_d = LIM_MIN;
    end
    if (rev_lim_d > LIM_MAX) begin
      rev_lim_d = LIM_MAX;
    end else if (rev_lim_d < LIM_MIN) begin
      rev_lim_d = LIM_MIN;
    end
    warn_en_d = warn_en_q;
    if (!boot_q || restart) begin
      warn_en_d = (overtravel_warning_setting == OTW_DIGIT_ON);
    end
  end

  // Settings register; limit changes land one cycle later
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_q    <= 1'b0;
      warn_en_q <= 1'b0;
      slim_q    <= '{enable_digit: SLIM_EN_NONE, check_digit: SLIM_CHK_OFF};
      fwd_lim_q <= FWD_LIM_RST;
      rev_lim_q <= REV_LIM_RST;
    end else if (clk_en) begin
      boot_q    <= 1'b1;
      warn_en_q <= warn_en_d;
      slim_q    <= soft_limit_function_setting;
      fwd_lim_q <= fwd_lim_d;
      rev_lim_q <= rev_lim_d;
    end
  end

  assign dir_en[DIR_FWD] = (slim_q.enable_digit == SLIM_EN_BOTH) ||
                           (slim_q.enable_digit == SLIM_EN_FWD);
  assign dir_en[DIR_REV] = (slim_q.enable_digit == SLIM_EN_BOTH) ||
                           (slim_q.enable_digit == SLIM_EN_REV);
  assign chk_on = (slim_q.check_digit == SLIM_CHK_ON);

  // ****************************************************************
  // Limit compares
  // ****************************************************************

  logic       armed_q;
  logic       armed_d;
  logic [1:0] pos_over;
  logic [1:0] tgt_over;

  // Feedback position against live limits
  tls_limit_cmp #(.W(W)) u_pos_cmp (
    .pos     (feedback_position),
    .fwd_lim (fwd_lim_q),
    .rev_lim (rev_lim_q),
    .dir_en  (dir_en),
    .armed   (armed_q),
    .over    (pos_over)
  );

  // Commanded target, only when the check digit asks
  tls_limit_cmp #(.W(W)) u_tgt_cmp (
    .pos     (host_cmd.target),
    .fwd_lim (fwd_lim_q),
    .rev_lim (rev_lim_q),
    .dir_en  (dir_en & {2{chk_on}}),
    .armed   (armed_q),
    .over    (tgt_over)
  );

  // Arming follows the reference point validity
  always_comb begin
    armed_d = armed_q;
    // arm on homing or valid set
    if (origin_return_done) begin
      armed_d = 1'b1;
    end else if (host_cmd.valid && host_cmd.kind == TLS_CMD_SET_POS) begin
      armed_d = host_cmd.ref_valid;
    end
  end

  // ****************************************************************
  // Command acceptance and motion direction
  // ****************************************************************

  tls_motion_t         st_q;
  tls_motion_t         st_d;
  logic                exec_valid_d;
  tls_cmd_kind_t       exec_kind_d;
  logic signed [W-1:0] exec_target_d;
  logic                target_clamped_d;
  logic                is_move;

  assign is_move = host_cmd.valid && (host_cmd.kind == TLS_CMD_POSITIONING ||
                                      host_cmd.kind == TLS_CMD_INTERP);

  // Every command passes; the warning is never consulted here
  always_comb begin
    exec_valid_d     = host_cmd.valid;
    exec_kind_d      = host_cmd.valid ? host_cmd.kind : TLS_CMD_NONE;
    exec_target_d    = host_cmd.target;
    target_clamped_d = 1'b0;
    if (is_move && tgt_over[DIR_FWD]) begin
      exec_target_d    = fwd_lim_q;
      target_clamped_d = 1'b1;
    end else if (is_move && tgt_over[DIR_REV]) begin
      exec_target_d    = rev_lim_q;
      target_clamped_d = 1'b1;
    end
    st_d = st_q;
    case (st_q)
      TLS_ST_IDLE, TLS_ST_FWD, TLS_ST_REV: begin
        if (is_move) begin
          if (exec_target_d > feedback_position) begin
            st_d = TLS_ST_FWD;
          end else if (exec_target_d < feedback_position) begin
            st_d = TLS_ST_REV;
          end else begin
            st_d = TLS_ST_IDLE;
          end
        end else if (motion_done) begin
          st_d = TLS_ST_IDLE;
        end
      end
      default: begin
        st_d = TLS_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Overtravel stop and warning
  // ****************************************************************

  logic [1:0] cause;
  logic [1:0] cause_q;
  logic [1:0] rise;
  logic [1:0] relevant;
  logic       warn_set;
  logic       warn_d;
  logic       stop_fwd_d;
  logic       stop_rev_d;

  assign cause[DIR_FWD] = forward_travel_block_input | pos_over[DIR_FWD];
  assign cause[DIR_REV] = reverse_travel_block_input | pos_over[DIR_REV];
  assign stop_fwd_d = cause[DIR_FWD];
  assign stop_rev_d = cause[DIR_REV];

  // Edge of the cause, so held overtravel never re-raises after a clear
  assign rise = cause & ~cause_q;
  assign relevant[DIR_FWD] = (st_q != TLS_ST_REV);
  assign relevant[DIR_REV] = (st_q != TLS_ST_FWD);

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    warn_set = warn_en_q && servo_power_on_cmd && |(rise & relevant);
    warn_d = warn_set || (overtravel_warning_code && !clear_alarm_cmd);
  end

  // ****************************************************************
  // State registers
  // ****************************************************************

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      armed_q                 <= 1'b0;
      st_q                    <= TLS_ST_IDLE;
      cause_q                 <= 2'h0;
      overtravel_warning_code <= 1'b0;
      ot_stop_fwd             <= 1'b0;
      ot_stop_rev             <= 1'b0;
      exec_valid              <= 1'b0;
      exec_kind               <= TLS_CMD_NONE;
      exec_target             <= '0;
      target_clamped          <= 1'b0;
    end else if (clk_en) begin
      armed_q                 <= armed_d;
      st_q                    <= st_d;
      cause_q                 <= cause;
      overtravel_warning_code <= warn_d;
      ot_stop_fwd             <= stop_fwd_d;
      ot_stop_rev             <= stop_rev_d;
      exec_valid              <= exec_valid_d;
      exec_kind               <= exec_kind_d;
      exec_target             <= exec_target_d;
      target_clamped          <= target_clamped_d;
    end
  end

  assign soft_limit_armed = armed_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_warn_needs_enable: assert property (
    (clk_en && !overtravel_warning_code && !warn_set) |=>
      !overtravel_warning_code)
    else $error("warning rose without a qualified cause");

  a_warn_dir_gate: assert property (
    (clk_en && st_q == TLS_ST_FWD && rise == 2'h2 &&
     !overtravel_warning_code) |=> !overtravel_warning_code)
    else $error("warning raised against command direction");

  a_warn_clear_cmd: assert property (
    (clk_en && clear_alarm_cmd && !warn_set) |=> !overtravel_warning_code)
    else $error("clear alarm did not clear the warning");

  a_warn_sticky: assert property (
    (clk_en && overtravel_warning_code && !clear_alarm_cmd) |=>
      overtravel_warning_code)
    else $error("warning dropped without clear");

  a_warn_enable_latch: assert property (
    (clk_en && boot_q && !restart) |=> $stable(warn_en_q))
    else $error("warning enable changed without restart");

  a_hw_stop_fwd: assert property (
    (clk_en && forward_travel_block_input) |=> ot_stop_fwd)
    else $error("forward block input gave no stop");

  a_soft_stop_rev: assert property (
    (clk_en && pos_over[DIR_REV]) |=> ot_stop_rev)
    else $error("reverse soft limit gave no stop");

  a_unarmed_quiet: assert property (
    !armed_q |-> (pos_over == 2'h0 && tgt_over == 2'h0))
    else $error("soft limit acted while unarmed");

  a_dir_none: assert property (
    (slim_q.enable_digit == SLIM_EN_NONE) |-> pos_over == 2'h0)
    else $error("soft limit acted while both disabled");

  a_arm_origin: assert property (
    (clk_en && origin_return_done) |=> soft_limit_armed)
    else $error("origin return did not arm limits");

  a_cmd_accept: assert property (
    (clk_en && host_cmd.valid && overtravel_warning_code) |=> exec_valid)
    else $error("command refused during warning");

  a_clamp_fwd: assert property (
    (clk_en && is_move && tgt_over[DIR_FWD]) |=>
      (target_clamped && exec_target == $past(fwd_lim_q)))
    else $error("forward target not replaced by limit");

  c_warn_raised: cover property (clk_en && warn_set);
  c_warn_clear: cover property (clk_en && clear_alarm_cmd &&
                                overtravel_warning_code);
  c_target_clamp: cover property (clk_en && is_move && |tgt_over);
  c_soft_stop: cover property (clk_en && |pos_over);

endmodule : tls_supervisor
